// *** pkg/temp_readout_map.svh ***
/*
 Offsets, field positions, reset values and timing counts of the
 temperature readout block. Assumes inclusion by bare name.
*/
`ifndef TEMP_READOUT_MAP_SVH
`define TEMP_READOUT_MAP_SVH
`define SLV_ADDR 7'h4c
`define A_LOC 8'h00
`define A_REMH 8'h01
`define A_STAT 8'h02
`define A_CFG 8'h03
`define A_CFG2 8'h09
`define A_LHS 8'h05
`define A_LHS2 8'h0b
`define A_RHM 8'h07
`define A_RHM2 8'h0d
`define A_RLM 8'h08
`define A_RLM2 8'h0e
`define A_ONESHOT 8'h0f
`define A_REML 8'h10
`define A_RHL 8'h13
`define A_RLL 8'h14
`define A_MSK 8'h16
`define A_CRIT 8'h19
`define A_MODE 8'hbf
`define CFG_POR 8'h00
`define CFG_WMASK 8'he7
`define CFG_ALTMSK 7
`define CFG_STBY 6
`define CFG_CRITOV 1
`define CFG_FLTQ 0
`define LHS_POR 8'h46
`define RHM_POR 8'h69
`define RLM_POR 8'h00
`define MSK_POR 8'ha4
`define MSK_ONES 8'ha4
`define MSK_LH 6
`define MSK_RH 4
`define MSK_RL 3
`define MSK_RC 1
`define CRIT_POR 8'h6e
`define MODE_POR 3'h0
`define F_GND_S 16'h8000
`define F_GND_U 16'h0000
`define F_VDD_S 16'h7f00
`define F_VDD_U 16'hff00
`define S_MAX 14'sh0fff
`define S_MIN -14'sh1000
`define CLIP 15'sh0040
`define SYS_PERIOD_NS 10
`define TIMEOUT_US 30000
`endif

// *** pkg/temp_readout_pkg.sv ***
/*
 Types of the temperature readout block.
 Assumes nothing of its surroundings.
*/
package temp_readout_pkg;
  typedef enum logic [3:0] {L_IDLE, L_ADDR, L_ACKA, L_CMD, L_ACKC, L_WD, L_ACKW, L_RD,
    L_RACK} link_st_t;
endpackage

// *** rtl/temp_readout.sv ***
/*
 Remote diode temperature readout: result formatting, diode fault
 handling, fault queue, one-shot conversion and a serial bus slave.
 Assumes sensor inputs on clk_sys, bus pins asynchronous, link_clk
 free-running and far faster than the bus clock.
*/
// Functional notes
// - Filter on: remote is 13-bit, 1/32 degree per bit.
// - Local and critical setpoint are 8-bit signed, 1 degree per bit.
// - Critical setpoint may also be 8-bit unsigned, 0 to 255.
// - Anode to ground forces -128 signed or 0 unsigned.
// - Anode to supply or open forces +127 signed or +255 unsigned.
// - Any diode fault sets the diode fault flag.
// - Diode fault flag alone never drives alert or critical output.
// - Forced readings are compared with setpoints, masks still apply.
// - Registers are read-only, write-only, or read/write at one or two addresses.
// - Bytes travel most significant bit first.
// - End of read accepts acknowledge or not-acknowledge.
// - Filter select: 00 none, 01 standard, 10 reserved, 11 enhanced.
// - Fault queue on: limit flag after three consecutive violations.
// - Fault queue off at reset, enable bit 0 turns it on.
// - One-shot write in standby runs one conversion.
// - One-shot data discarded, reads zero.
// - Clock or data low past timeout returns slave to idle.
// - START anywhere restarts with an address byte.
// - Filter off: 11-bit, 1/8 degree per bit.
// - Left-justified 16-bit words, unused low bits zero.
// - Results saturate at full scale.
`timescale 1ns/1ps
`include "temp_readout_map.svh"
module temp_readout
  import temp_readout_pkg::*;
#(
  parameter int TIMEOUT_CYC = `TIMEOUT_US * 1000 / `SYS_PERIOD_NS
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic signed [7:0] local_temp,
  input wire logic signed [13:0] remote_temp,
  input wire logic conv_done,
  input wire logic diode_short_gnd,
  input wire logic diode_short_vdd,
  output logic conv_start,
  output logic alert_out_n,
  output logic critical_temp_output
);
  // Link domain
  logic [2:0] scl_sy_q, sda_sy_q, to_sy_q;
  link_st_t st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wdat_q, wdat_d;
  logic [3:0] cnt_q, cnt_d;
  logic rw_q, rw_d, drv_q, drv_d, nack_q, nack_d;
  logic wr_tg_q, wr_tg_d, rd_tg_q, rd_tg_d;
  logic scl_r, scl_f, start, stop, to_ev;
  // System domain
  logic [1:0] scl_ls_q, sda_ls_q;
  logic [2:0] wr_sy_q, rd_sy_q;
  logic [21:0] to_cnt_q, to_cnt_d;
  logic to_tg_q, to_tg_d;
  logic [7:0] cfg_q, cfg_d, lhs_q, lhs_d, rhm_q, rhm_d, rlm_q, rlm_d, msk_q, msk_d;
  logic [7:0] crit_q, crit_d, loc_q, loc_d, rdat_q, rdat_d;
  logic [2:0] rhl_q, rhl_d, rll_q, rll_d, mode_q, mode_d;
  logic [15:0] rem_q, rem_d;
  logic signed [13:0] filt_q, filt_d, src;
  logic signed [14:0] dlt;
  logic [1:0] hc_q, hc_d, lc_q, lc_d;
  logic busy_q, busy_d, osh_q, osh_d, cs_q, cs_d, al_q, al_d, cr_q, cr_d;
  logic rh_q, rh_d, rl_q, rl_d, df_q, df_d, rc_q, rc_d, lh_q, lh_d;
  logic wr_ev, rd_ev, usf, filt_on, over_h, under_l, go;
  logic [10:0] rv11;

  assign scl_r = scl_sy_q[1] & ~scl_sy_q[2];
  assign scl_f = ~scl_sy_q[1] & scl_sy_q[2];
  assign start = scl_sy_q[1] & scl_sy_q[2] & ~sda_sy_q[1] & sda_sy_q[2];
  assign stop = scl_sy_q[1] & scl_sy_q[2] & sda_sy_q[1] & ~sda_sy_q[2];
  assign to_ev = to_sy_q[1] ^ to_sy_q[2];
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drv_q;

  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    wdat_d = wdat_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    drv_d = drv_q;
    nack_d = nack_q;
    wr_tg_d = wr_tg_q;
    rd_tg_d = rd_tg_q;
    if (to_ev)
    begin
      st_d = L_IDLE;
      drv_d = 1'b0;
    end
    else if (start)
    begin
      st_d = L_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end
    else if (stop)
    begin
      st_d = L_IDLE;
      drv_d = 1'b0;
    end
    else if (scl_r)
    begin
      cnt_d = cnt_q + 4'h1;
      if (st_q == L_RACK)
        nack_d = sda_sy_q[1];
      else if (st_q != L_RD)
        sh_d = {sh_q[6:0], sda_sy_q[1]};
    end
    else if (scl_f)
    begin
      case (st_q)
        L_ADDR:
          if (cnt_q == 4'h8)
          begin
            cnt_d = 4'h0;
            if (sh_q[7:1] == `SLV_ADDR)
            begin
              drv_d = 1'b1;
              rw_d = sh_q[0];
              st_d = L_ACKA;
              if (sh_q[0])
                rd_tg_d = ~rd_tg_q;
            end
            else
              st_d = L_IDLE;
          end
        L_CMD:
          if (cnt_q == 4'h8)
          begin
            ptr_d = sh_q;
            drv_d = 1'b1;
            cnt_d = 4'h0;
            st_d = L_ACKC;
          end
        L_WD:
          if (cnt_q == 4'h8)
          begin
            wdat_d = sh_q;
            wr_tg_d = ~wr_tg_q;
            drv_d = 1'b1;
            cnt_d = 4'h0;
            st_d = L_ACKW;
          end
        L_ACKA, L_RACK:
        begin
          cnt_d = 4'h0;
          if (st_q == L_ACKA && !rw_q)
          begin
            drv_d = 1'b0;
            st_d = L_CMD;
          end
          else if (st_q == L_RACK && nack_q)
          begin
            drv_d = 1'b0;
            st_d = L_IDLE;
          end
          else
          begin
            drv_d = ~rdat_q[7];
            sh_d = {rdat_q[6:0], 1'b0};
            st_d = L_RD;
          end
        end
        L_ACKC, L_ACKW:
        begin
          drv_d = 1'b0;
          cnt_d = 4'h0;
          st_d = L_WD;
        end
        L_RD:
          if (cnt_q == 4'h8)
          begin
            drv_d = 1'b0;
            cnt_d = 4'h0;
            rd_tg_d = ~rd_tg_q; // Prefetch in case the host acknowledges
            st_d = L_RACK;
          end
          else
          begin
            drv_d = ~sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
          end
        default: ;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      to_sy_q <= 3'h0;
      st_q <= L_IDLE;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      wdat_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
      nack_q <= 1'b0;
      wr_tg_q <= 1'b0;
      rd_tg_q <= 1'b0;
    end
    else
    begin
      scl_sy_q <= {scl_sy_q[1:0], scl_i};
      sda_sy_q <= {sda_sy_q[1:0], sda_i};
      to_sy_q <= {to_sy_q[1:0], to_tg_q};
      st_q <= st_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      wdat_q <= wdat_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      drv_q <= drv_d;
      nack_q <= nack_d;
      wr_tg_q <= wr_tg_d;
      rd_tg_q <= rd_tg_d;
    end
  end

  // Requests carry ptr_q/wdat_q, loaded no later than the toggle and held long after it lands
  assign wr_ev = wr_sy_q[1] ^ wr_sy_q[2];
  assign rd_ev = rd_sy_q[1] ^ rd_sy_q[2];
  assign usf = mode_q[0];
  assign filt_on = mode_q[1];
  assign go = !busy_q && (!cfg_q[`CFG_STBY] || osh_q);

  always_comb
  begin
    to_cnt_d = 22'h0;
    to_tg_d = to_tg_q;
    if (!scl_ls_q[1] || !sda_ls_q[1])
    begin
      to_cnt_d = (to_cnt_q == 22'(TIMEOUT_CYC)) ? to_cnt_q : to_cnt_q + 22'h1;
      if (to_cnt_q == 22'(TIMEOUT_CYC - 1))
        to_tg_d = ~to_tg_q;
    end
    cfg_d = cfg_q;
    lhs_d = lhs_q;
    rhm_d = rhm_q;
    rlm_d = rlm_q;
    rhl_d = rhl_q;
    rll_d = rll_q;
    msk_d = msk_q;
    crit_d = crit_q;
    mode_d = mode_q;
    rdat_d = rdat_q;
    osh_d = osh_q;
    // Clear before the write decode so a one-shot write in the start cycle is kept
    if (go)
      osh_d = 1'b0;
    if (wr_ev)
      case (ptr_q)
        `A_CFG, `A_CFG2: cfg_d = wdat_q & `CFG_WMASK;
        `A_LHS, `A_LHS2: lhs_d = wdat_q;
        `A_RHM, `A_RHM2: rhm_d = wdat_q;
        `A_RLM, `A_RLM2: rlm_d = wdat_q;
        `A_RHL: rhl_d = wdat_q[7:5];
        `A_RLL: rll_d = wdat_q[7:5];
        `A_MSK: msk_d = wdat_q | `MSK_ONES;
        `A_CRIT: crit_d = cfg_q[`CFG_CRITOV] ? wdat_q : crit_q;
        `A_MODE: mode_d = wdat_q[2:0];
        `A_ONESHOT: osh_d = cfg_q[`CFG_STBY];
        default: ;
      endcase
    if (rd_ev)
      case (ptr_q)
        `A_LOC: rdat_d = loc_q;
        `A_REMH: rdat_d = rem_q[15:8];
        `A_REML: rdat_d = rem_q[7:0];
        `A_STAT: rdat_d = {busy_q, lh_q, 1'b0, rh_q, rl_q, df_q, rc_q, 1'b0};
        `A_CFG, `A_CFG2: rdat_d = cfg_q;
        `A_LHS, `A_LHS2: rdat_d = lhs_q;
        `A_RHM, `A_RHM2: rdat_d = rhm_q;
        `A_RLM, `A_RLM2: rdat_d = rlm_q;
        `A_RHL: rdat_d = {rhl_q, 5'h00};
        `A_RLL: rdat_d = {rll_q, 5'h00};
        `A_MSK: rdat_d = msk_q;
        `A_CRIT: rdat_d = crit_q;
        `A_MODE: rdat_d = {5'h00, mode_q};
        default: rdat_d = 8'h00;
      endcase
    cs_d = go;
    busy_d = go || (busy_q && !conv_done);
    // Filter: one quarter step; enhanced mode clips the step first
    dlt = {remote_temp[13], remote_temp} - {filt_q[13], filt_q};
    if (mode_q[2:1] == 2'b11)
      dlt = (dlt > `CLIP) ? `CLIP : ((dlt < -`CLIP) ? -`CLIP : dlt);
    filt_d = conv_done ? filt_q + 14'(dlt >>> 2) : filt_q;
    src = filt_on ? filt_d : (remote_temp & ~14'sh0003);
    if (usf)
      src = (src < 14'sh0) ? 14'sh0 : src;
    else
      src = (src > `S_MAX) ? `S_MAX : ((src < `S_MIN) ? `S_MIN : src);
    rem_d = {src[12:0], 3'h0};
    if (diode_short_gnd)
      rem_d = usf ? `F_GND_U : `F_GND_S;
    else if (diode_short_vdd)
      rem_d = usf ? `F_VDD_U : `F_VDD_S;
    rv11 = rem_d[15:5];
    over_h = usf ? (rv11 > {rhm_q, rhl_q}) : ($signed(rv11) > $signed({rhm_q, rhl_q}));
    under_l = usf ? (rv11 < {rlm_q, rll_q}) : ($signed(rv11) < $signed({rlm_q, rll_q}));
    hc_d = over_h ? ((hc_q == 2'h3) ? hc_q : hc_q + 2'h1) : 2'h0;
    lc_d = under_l ? ((lc_q == 2'h3) ? lc_q : lc_q + 2'h1) : 2'h0;
    rh_d = cfg_q[`CFG_FLTQ] ? (hc_d == 2'h3) : over_h;
    rl_d = cfg_q[`CFG_FLTQ] ? (lc_d == 2'h3) : under_l;
    rc_d = usf ? (rem_d[15:8] > crit_q) : ($signed(rem_d[15:8]) > $signed(crit_q));
    lh_d = $signed(local_temp) > $signed(lhs_q);
    df_d = diode_short_gnd || diode_short_vdd;
    loc_d = local_temp;
    if (!conv_done)
    begin
      rem_d = rem_q;
      hc_d = hc_q;
      lc_d = lc_q;
      rh_d = rh_q;
      rl_d = rl_q;
      rc_d = rc_q;
      lh_d = lh_q;
      df_d = df_q;
      loc_d = loc_q;
    end
    al_d = !cfg_q[`CFG_ALTMSK] && ((lh_q && !msk_q[`MSK_LH]) || (rh_q && !msk_q[`MSK_RH])
      || (rl_q && !msk_q[`MSK_RL]) || (rc_q && !msk_q[`MSK_RC]));
    cr_d = rc_q && !msk_q[`MSK_RC];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_ls_q <= 2'h3;
      sda_ls_q <= 2'h3;
      wr_sy_q <= 3'h0;
      rd_sy_q <= 3'h0;
      to_cnt_q <= 22'h0;
      to_tg_q <= 1'b0;
      cfg_q <= `CFG_POR;
      lhs_q <= `LHS_POR;
      rhm_q <= `RHM_POR;
      rlm_q <= `RLM_POR;
      rhl_q <= 3'h0;
      rll_q <= 3'h0;
      msk_q <= `MSK_POR;
      crit_q <= `CRIT_POR;
      mode_q <= `MODE_POR;
      rdat_q <= 8'h00;
      {osh_q, busy_q, cs_q, al_q, cr_q} <= 5'h0;
      {rh_q, rl_q, rc_q, lh_q, df_q} <= 5'h0;
      filt_q <= 14'sh0;
      rem_q <= 16'h0000;
      loc_q <= 8'h00;
      hc_q <= 2'h0;
      lc_q <= 2'h0;
    end
    else
    begin
      scl_ls_q <= {scl_ls_q[0], scl_i};
      sda_ls_q <= {sda_ls_q[0], sda_i};
      wr_sy_q <= {wr_sy_q[1:0], wr_tg_q};
      rd_sy_q <= {rd_sy_q[1:0], rd_tg_q};
      to_cnt_q <= to_cnt_d;
      to_tg_q <= to_tg_d;
      cfg_q <= cfg_d;
      lhs_q <= lhs_d;
      rhm_q <= rhm_d;
      rlm_q <= rlm_d;
      rhl_q <= rhl_d;
      rll_q <= rll_d;
      msk_q <= msk_d;
      crit_q <= crit_d;
      mode_q <= mode_d;
      rdat_q <= rdat_d;
      {osh_q, busy_q, cs_q, al_q, cr_q} <= {osh_d, busy_d, cs_d, al_d, cr_d};
      {rh_q, rl_q, rc_q, lh_q, df_q} <= {rh_d, rl_d, rc_d, lh_d, df_d};
      filt_q <= filt_d;
      rem_q <= rem_d;
      loc_q <= loc_d;
      hc_q <= hc_d;
      lc_q <= lc_d;
    end
  end

  assign conv_start = cs_q;
  assign alert_out_n = ~al_q;
  assign critical_temp_output = cr_q;

  fault_gnd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_done && diode_short_gnd && !usf |=> rem_q == 16'h8000) else $error("gnd fault word");
  fault_vdd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_done && !diode_short_gnd && diode_short_vdd && usf |=> rem_q == 16'hff00)
    else $error("supply fault word");
  fault_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_done && diode_short_vdd |=> df_q) else $error("fault flag not set");
  flag_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !lh_q && !rh_q && !rl_q && !rc_q |=> alert_out_n && !critical_temp_output)
    else $error("alert without cause");
  low_bits_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_done && !filt_on |=> rem_q[4:0] == 5'h00) else $error("unfiltered low bits");
  oneshot_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_ev && ptr_q == `A_ONESHOT |=> rdat_q == 8'h00) else $error("one-shot read");
  queue_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_done && cfg_q[`CFG_FLTQ] && hc_q == 2'h0 |=> !rh_q) else $error("queue early");
  filter_clip_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_done && mode_q[2:1] == 2'b11 |=> (filt_q - $past(filt_q)) <= 14'sh0010
    && (filt_q - $past(filt_q)) >= -14'sh0010) else $error("enhanced step not clipped");
  oneshot_go_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_ev && ptr_q == `A_ONESHOT && cfg_q[`CFG_STBY] && !busy_q ##1 !busy_q |=> conv_start)
    else $error("one-shot start missing");
  timeout_idle_a: assert property (@(posedge link_clk) disable iff (!resetn)
    to_ev |=> st_q == L_IDLE && !drv_q) else $error("timeout not idle");
  start_addr_a: assert property (@(posedge link_clk) disable iff (!resetn)
    start && !to_ev |=> st_q == L_ADDR && cnt_q == 4'h0) else $error("start ignored");
  read_done_c: cover property (@(posedge link_clk) disable iff (!resetn)
    st_q == L_RACK && scl_f && nack_q);
  write_done_c: cover property (@(posedge link_clk) disable iff (!resetn) st_q == L_ACKW);
  fault_c: cover property (@(posedge clk_sys) disable iff (!resetn) conv_done && diode_short_gnd);
  timeout_c: cover property (@(posedge link_clk) disable iff (!resetn) to_ev);
endmodule

// *** bench/smbus_host.sv ***
/*
 Behavioural bus host that reads and writes the block's byte registers.
 Assumes a pull-up on the data line, built by the bench from sda_pull.
*/
`timescale 1ns/1ps
`include "temp_readout_map.svh"
module smbus_host
#(
  parameter realtime Q = 200
)
(
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Also used as a repeated start in mid-frame
  task automatic start_cond();
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop_cond();
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask

  // Sends b (1 releases the line) and samples the line while clock is high
  task automatic bit_io(input logic b, output logic s);
    sda_pull = ~b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic rel, output logic [7:0] q,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], q[i]);
    end
    bit_io(rel, s);
    ack = ~s;
  endtask

  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    byte_io({`SLV_ADDR, 1'b0}, 1'b1, q, a0);
    byte_io(cmd, 1'b1, q, a1);
    byte_io(d, 1'b1, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [7:0] cmd, input logic two, output logic [7:0] d);
    logic [7:0] q;
    logic a;
    start_cond();
    byte_io({`SLV_ADDR, 1'b0}, 1'b1, q, a);
    byte_io(cmd, 1'b1, q, a);
    start_cond();
    byte_io({`SLV_ADDR, 1'b1}, 1'b1, q, a);
    if (two)
    begin
      byte_io(8'hff, 1'b0, d, a);
    end
    // Last byte ends with a not-acknowledge
    byte_io(8'hff, 1'b1, d, a);
    stop_cond();
  endtask

  // Releases the data line and holds the clock low for time t
  task automatic hold_scl_low(input realtime t);
    sda_pull = 1'b0;
    scl = 1'b0;
    #t;
  endtask
endmodule

// *** bench/remote_temp_readout_and_bus_slave_bench.sv ***
/*
 Self-checking bench of the temperature readout block with a bus host.
 Assumes the design header and package are compiled first.
*/
`timescale 1ns/1ps
`include "temp_readout_map.svh"
module remote_temp_readout_and_bus_slave_bench;
  import temp_readout_pkg::*;
  logic clk_sys;
  logic resetn;
  logic link_clk;
  logic scl;
  logic sda_pull;
  wire logic sda_line;
  logic sda_o;
  logic sda_oe_n;
  logic signed [7:0] local_temp;
  logic signed [13:0] remote_temp;
  logic conv_done;
  logic diode_short_gnd;
  logic diode_short_vdd;
  logic conv_start;
  logic alert_out_n;
  logic critical_temp_output;
  logic [7:0] rdata;
  logic dummy;
  int fails;
  int checked;
  int starts;
  int n0;

  // Open-drain data line with pull-up
  assign sda_line = ~(sda_pull | (~sda_oe_n & ~sda_o));

  temp_readout #(.TIMEOUT_CYC(4000)) u_temp_readout (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .link_clk(link_clk),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .local_temp(local_temp),
    .remote_temp(remote_temp),
    .conv_done(conv_done),
    .diode_short_gnd(diode_short_gnd),
    .diode_short_vdd(diode_short_vdd),
    .conv_start(conv_start),
    .alert_out_n(alert_out_n),
    .critical_temp_output(critical_temp_output)
  );

  smbus_host u_smbus_host (
    .scl(scl),
    .sda_pull(sda_pull),
    .sda(sda_line)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  // Sensor front end: answers each start with a done pulse
  initial
  begin
    conv_done = 1'b0;
    forever
    begin
      @(posedge clk_sys iff conv_start === 1'b1);
      repeat (20) @(negedge clk_sys);
      conv_done = 1'b1;
      @(negedge clk_sys);
      conv_done = 1'b0;
    end
  end

  always @(posedge clk_sys)
  begin
    if (conv_start === 1'b1)
    begin
      starts <= starts + 1;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t ns: value mismatch, seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic ok;
    u_smbus_host.write_reg(cmd, d, ok);
    check({7'h0, ok}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] cmd);
    u_smbus_host.read_reg(cmd, 1'b0, rdata);
  endtask

  task automatic reset_values();
    u_smbus_host.read_reg(`A_CFG, 1'b1, rdata);
    check(rdata, 8'h00);
    rd(`A_CRIT);
    check(rdata, 8'h6e);
  endtask

  task automatic restart_and_format();
    u_smbus_host.start_cond();
    for (int i = 0; i < 4; i++)
    begin
      u_smbus_host.bit_io(i[0], dummy);
    end
    rd(`A_LOC);
    check(rdata, 8'h19);
    rd(`A_REMH);
    check(rdata, 8'h19);
    rd(`A_REML);
    check(rdata, 8'ha0);
    check({7'h0, alert_out_n}, 8'h01);
    @(negedge clk_sys);
    remote_temp = 14'sh2000;
    settle(100);
    rd(`A_REMH);
    check(rdata, 8'h80);
  endtask

  task automatic diode_faults();
    wr(`A_MSK, 8'hff);
    remote_temp = 14'sd821;
    diode_short_vdd = 1'b1;
    settle(100);
    check({7'h0, alert_out_n}, 8'h01);
    check({7'h0, critical_temp_output}, 8'h00);
    rd(`A_STAT);
    check({1'b0, rdata[6:0]}, 8'h16);
    rd(`A_REMH);
    check(rdata, 8'h7f);
    wr(`A_MSK, 8'ha4);
    settle(100);
    check({7'h0, alert_out_n}, 8'h00);
    check({7'h0, critical_temp_output}, 8'h01);
    wr(`A_MODE, 8'h01);
    rd(`A_REMH);
    check(rdata, 8'hff);
    rd(`A_STAT);
    check({1'b0, rdata[6:0]}, 8'h16);
    diode_short_vdd = 1'b0;
    diode_short_gnd = 1'b1;
    settle(100);
    rd(`A_REMH);
    check(rdata, 8'h00);
    check({7'h0, alert_out_n}, 8'h01);
    check({7'h0, critical_temp_output}, 8'h00);
    rd(`A_STAT);
    check({1'b0, rdata[6:0]}, 8'h04);
    wr(`A_MODE, 8'h00);
    rd(`A_REMH);
    check(rdata, 8'h80);
    diode_short_gnd = 1'b0;
  endtask

  // Steps the input down onto the value so the filter settles exactly on it
  task automatic filter_modes();
    wr(`A_MODE, 8'h02);
    remote_temp = 14'sh03e8;
    settle(300);
    remote_temp = 14'sh0335;
    settle(600);
    rd(`A_REML);
    check(rdata, 8'ha8);
    wr(`A_MODE, 8'h06);
    remote_temp = 14'sh03e8;
    settle(300);
    remote_temp = 14'sh0335;
    settle(600);
    rd(`A_REML);
    check(rdata, 8'ha8);
    wr(`A_MODE, 8'h04);
    rd(`A_REML);
    check(rdata, 8'ha0);
  endtask

  task automatic fault_queue();
    wr(`A_CFG, 8'h01);
    remote_temp = 14'sh0dc0;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys iff conv_done === 1'b1);
      repeat (2) @(negedge clk_sys);
      check({7'h0, alert_out_n}, (i == 2) ? 8'h00 : 8'h01);
    end
    remote_temp = 14'sh0335;
  endtask

  task automatic bus_timeout();
    logic [7:0] a;
    a = {`SLV_ADDR, 1'b0};
    u_smbus_host.start_cond();
    for (int i = 7; i >= 0; i--)
    begin
      u_smbus_host.bit_io(a[i], dummy);
    end
    fork
      u_smbus_host.hold_scl_low(60000);
      begin
        settle(30);
        check({7'h0, sda_oe_n}, 8'h00);
        settle(5900);
        check({7'h0, sda_oe_n}, 8'h01);
      end
    join
    u_smbus_host.stop_cond();
  endtask

  task automatic one_shot();
    wr(`A_CFG, 8'h40);
    settle(100);
    n0 = starts;
    settle(300);
    check(8'(starts - n0), 8'h00);
    wr(`A_ONESHOT, 8'hff);
    settle(100);
    check(8'(starts - n0), 8'h01);
    rd(`A_ONESHOT);
    check(rdata, 8'h00);
  endtask

  initial
  begin
    #1000000;
    fails++;
    end_of_test();
  end

  initial
  begin
    fails = 0;
    checked = 0;
    starts = 0;
    resetn = 1'b0;
    local_temp = 8'sh19;
    remote_temp = 14'sd821;
    diode_short_gnd = 1'b0;
    diode_short_vdd = 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    settle(40);
    reset_values();
    restart_and_format();
    diode_faults();
    filter_modes();
    fault_queue();
    bus_timeout();
    one_shot();
    end_of_test();
  end
endmodule
